// File: sdrpin_checker.sv
// assertion checker for the x16 dram pin interface
module sdrpin_checker
    import sdrpin_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             rst,
    input wire sdrpin_cmd_t      cmd,
    input wire logic [LANES-1:0] dm,
    input wire logic [DQ_W-1:0]  dq_i,
    input wire logic [DQ_W-1:0]  dq_o,
    input wire logic             dq_oe,
    input wire logic [LANES-1:0] dqs_i,
    input wire logic [LANES-1:0] dqs_o,
    input wire logic [LANES-1:0] dqs_c_o,
    input wire logic             dqs_oe,
    input wire logic             odt_on,
    input wire sdrpin_pwr_t      power_mode,
    input wire logic             write_stall
);
    // ==========================================
    // pin decodes, plain signals so $past sees one name
    logic rd_pin;
    logic cke_pin;
    logic odt_pin;
    assign rd_pin  = !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == 3'h5;
    assign cke_pin = cmd.cke;
    assign odt_pin = cmd.odt;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ==========================================
    // read strobes and data
    a_strobe_pair:
        assert property (dq_oe == dqs_oe) else $error("strobe enable differs from data enable");
    a_strobe_compl:
        assert property (dqs_oe |-> dqs_c_o == ~dqs_o) else $error("strobe pair not complementary");
    a_strobe_toggle:
        assert property (dq_oe && $past(dq_oe) |-> dqs_o == ~$past(dqs_o)) else $error("strobe did not toggle");
    a_first_high:
        assert property ($rose(dq_oe) |-> dqs_o == 2'h3) else $error("first beat strobe not high");
    a_read_cause:
        assert property ($rose(dq_oe) |-> $past(rd_pin, 4)) else $error("data without selected read");
    a_burst_min:
        assert property ($rose(dq_oe) |-> dq_oe[*4]) else $error("burst shorter than four beats");

    // ==========================================
    // reset, termination and power
    a_reset_quiet:
        assert property (disable iff (1'b0) rst |-> !dq_oe && !dqs_oe && !odt_on && power_mode == PWR_ON)
            else $error("outputs active in reset");
    a_odt_cause:
        assert property ($rose(odt_on) |-> $past(odt_pin) || $past(odt_pin, 2)) else $error("odt on without pin");
    a_sref_exit:
        assert property (power_mode == PWR_SREF && cke_pin |=> power_mode != PWR_SREF)
            else $error("self refresh not left");
    a_pd_entry:
        assert property (power_mode != PWR_ON && $past(power_mode) == PWR_ON |-> !$past(cke_pin, 2))
            else $error("power-down without clock enable low");
endmodule

bind sdrpin_top sdrpin_checker u_sdrpin_checker (
    .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .dm(dm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe), .odt_on(odt_on),
    .power_mode(power_mode), .write_stall(write_stall)
);

// File: sdrpin_ctrl_model.sv
// behavioural memory controller driving the dram pins
module sdrpin_ctrl_model
    import sdrpin_pkg::*;
(
    input  wire logic             clk_sys,
    output sdrpin_cmd_t           cmd,
    output logic      [LANES-1:0] dm,
    output logic      [DQ_W-1:0]  dq_i,
    output logic      [LANES-1:0] dqs_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy = 1'b0;

    // ==========================================
    // deselected with clock enable low until told otherwise
    initial begin
        cmd = {2'h1, 3'h7, 18'h0};
        dm = 2'h0;
        dq_i = 16'h0;
        dqs_i = 2'h0;
    end

    // standard ras/cas/we code, one edge then deselect
    task automatic put(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a,
                       input logic cs_n = 1'b0, input logic cke = 1'b1, input logic odt = 1'b0);
        @(posedge clk_sys);
        #1;
        {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} = {cs_n, op};
        cmd.ba = ba;
        cmd.addr = a;
        cmd.cke = cke;
        cmd.odt = odt;
        @(posedge clk_sys);
        #1;
        {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} = 4'hf;
    endtask

    // lane strobes toggle once per beat, data held a whole cycle
    task automatic wburst(input logic [15:0] d [8], input logic [1:0] m [8], input int n);
        busy = 1'b1;
        for (int k = 0; k < n; k++) begin
            @(posedge clk_sys);
            #1;
            dq_i = d[k];
            dm = m[k];
            dqs_i = ~dqs_i;
        end
        busy = 1'b0;
    endtask

    // released data lines wander so a stale beat cannot pass for a fresh one
    always @(posedge clk_sys) begin
        if (!busy) begin
            #1;
            dq_i = ~dq_i;
        end
    end
endmodule

// File: sdrpin_fifo.sv
// small synchronous fifo with valid/ready on both sides
module sdrpin_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    // full and empty come from the count, never from pointer guesses
    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage has no reset, only pointers and count do
    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at depth, which is a power of two
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// File: sdrpin_mem.sv
// byte-writable single-port array with registered read data
module sdrpin_mem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              re,
    input  wire logic              we,
    input  wire logic [AW-1:0]     addr,
    input  wire logic [DW-1:0]     wdata,
    input  wire logic [DW/8-1:0]   be,
    output logic      [DW-1:0]     rdata
);
    logic [DW-1:0] cells [2**AW];

    // one lane per byte enable; masked lanes keep their old contents
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < DW/8; i++) begin
            if (we && be[i]) begin
                cells[addr][i*8 +: 8] <= wdata[i*8 +: 8];
            end
        end
    end

    // read port registered so the data leave a flop
    always_ff @(posedge clk_sys) begin
        if (re) begin
            rdata <= cells[addr];
        end
    end
endmodule

// File: sdrpin_pkg.sv
// shared types and constants for the x16 ddr pin command interface
package sdrpin_pkg;

    // ==================================================
    // pin widths
    localparam int ROW_W   = 14;
    localparam int ADDR_W  = 14;
    localparam int BANK_W  = 3;
    localparam int NBANK   = 8;
    localparam int DQ_W    = 16;
    localparam int LANES   = 2;
    localparam int NMR     = 4;

    // ==================================================
    // address bit positions
    localparam int A_AP    = 10;   // auto precharge / precharge-all
    localparam int A_BC    = 12;   // on-the-fly burst chop select
    localparam int COL_HI  = 4;    // column bits kept by the small array

    // ==================================================
    // mode register fields
    localparam int MR_BL_LO    = 0;
    localparam int MR_BL_HI    = 1;
    localparam int MR_RTT_B0   = 2;
    localparam int MR_RTT_B1   = 6;
    localparam int MR_RTT_B2   = 9;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;

    // ==================================================
    // burst lengths and buffer sizes
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;
    localparam int FIFO_DEPTH = 8;
    localparam int MEM_AW     = BANK_W + 1 + 3;   // bank, column bit 4, beat

    // ==================================================
    // command pins sampled together each clock
    typedef struct packed {
        logic                 cke;
        logic                 cs_n;
        logic                 ras_n;
        logic                 cas_n;
        logic                 we_n;
        logic                 odt;
        logic [BANK_W-1:0]    ba;
        logic [ADDR_W-1:0]    addr;
    } sdrpin_cmd_t;

    // one write beat on its way to the array
    typedef struct packed {
        logic [MEM_AW-1:0]    addr;
        logic [DQ_W-1:0]      data;
        logic [LANES-1:0]     be;
    } sdrpin_beat_t;

    typedef enum logic [3:0] {
        OP_MRS, OP_REF, OP_PRE, OP_ACT, OP_WR, OP_RD, OP_ZQ, OP_NOP, OP_DESEL
    } sdrpin_op_t;

    typedef enum logic [1:0] {
        PWR_ON, PWR_APD, PWR_PPD, PWR_SREF
    } sdrpin_pwr_t;

    typedef enum logic [1:0] {
        BST_IDLE, BST_WRITE, BST_READ
    } sdrpin_bst_t;

endpackage

// File: sdrpin_top.sv
// pin-level command, address, mask, strobe and termination logic of the x16 dram
//
// Behaviour
// - act takes row; rd/wr take column, ap
// - precharge: a10 low one bank, high all
// - load mode takes opcode from address
// - otf chop: a12 high eight, low four
// - bank lines select the command's bank
// - bank lines pick one of four mode registers
// - inputs captured on rising clock crossing
// - cke low enters power-down or self refresh
// - cke synchronous except self refresh exit
// - power-down gates receivers except cke, odt, reset
// - chip select high masks every command
// - strobes with chip select encode command
// - lower mask high drops lower byte
// - upper mask high drops upper byte
// - odt switches termination unless mode disables
// - reset acts asynchronously
// - per-lane strobe: edge-aligned reads, centered writes
module sdrpin_top
    import sdrpin_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire sdrpin_cmd_t        cmd,
    input  wire logic [LANES-1:0]   dm,
    input  wire logic [DQ_W-1:0]    dq_i,
    output logic      [DQ_W-1:0]    dq_o,
    output logic                    dq_oe,
    input  wire logic [LANES-1:0]   dqs_i,
    output logic      [LANES-1:0]   dqs_o,
    output logic      [LANES-1:0]   dqs_c_o,
    output logic                    dqs_oe,
    output logic                    odt_on,
    output sdrpin_pwr_t             power_mode,
    output logic                    write_stall
);

    // ==================================================
    // decode helpers
    // standard encoding of cs, ras, cas, we
    function automatic sdrpin_op_t op_decode(input sdrpin_cmd_t c);
        sdrpin_op_t op;
        op = OP_NOP;
        if (c.cs_n) begin
            op = OP_DESEL;
        end else begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'h0:    op = OP_MRS;
                3'h1:    op = OP_REF;
                3'h2:    op = OP_PRE;
                3'h3:    op = OP_ACT;
                3'h4:    op = OP_WR;
                3'h5:    op = OP_RD;
                3'h6:    op = OP_ZQ;
                default: op = OP_NOP;
            endcase
        end
        return op;
    endfunction

    // burst length from mode register field and a12
    function automatic logic [3:0] burst_beats(input logic [1:0] bl, input logic a12);
        logic [3:0] n;
        n = BEATS_FULL;
        case (bl)
            BL_FIXED8: n = BEATS_FULL;
            BL_FIXED4: n = BEATS_CHOP;
            BL_OTF:    n = a12 ? BEATS_FULL : BEATS_CHOP;
            default:   n = BEATS_FULL;
        endcase
        return n;
    endfunction

    // ==================================================
    // declarations
    sdrpin_cmd_t          cmd_q;
    logic                 cke_prev;
    sdrpin_op_t           op;
    logic                 cmd_ok;
    logic [ADDR_W-1:0]    mode_reg [NMR];
    logic [NBANK-1:0]     bank_open;
    logic [ROW_W-1:0]     bank_row [NBANK];
    sdrpin_bst_t          bst;
    logic [3:0]           beat;
    logic [3:0]           beat_total;
    logic [BANK_W-1:0]    bst_bank;
    logic [COL_HI:0]      bst_col;
    logic                 bst_ap;
    logic                 bst_last;
    logic [LANES-1:0]     dqs_prev;
    sdrpin_beat_t         wbeat;
    logic                 wbeat_valid;
    logic                 fifo_in_ready;
    sdrpin_beat_t         drain;
    logic                 drain_valid;
    logic                 drain_ready;
    logic                 mem_re;
    logic [MEM_AW-1:0]    mem_addr;
    logic [DQ_W-1:0]      mem_rdata;
    logic                 rd_v1;
    logic                 rd_lsb1;
    logic                 rtt_enabled;
    logic                 act_cmd;
    logic                 pre_one;
    logic                 pre_all;
    logic                 ap_close;

    // ==================================================
    // pin capture
    // rising-crossing capture
    // every control and address pin is registered on the rising edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_q    <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                          odt: 1'b0, ba: '0, addr: '0};
            cke_prev <= 1'b0;
        end else begin
            cmd_q    <= cmd;
            cke_prev <= cmd_q.cke;
        end
    end

    // joint command encoding
    // commands other than self refresh entry are taken only while awake and clocked
    assign op     = op_decode(cmd_q);
    assign cmd_ok = (power_mode == PWR_ON) && cmd_q.cke && cke_prev;

    // ==================================================
    // power state
    // cke low entry choice
    // sync entry, async sr exit
    // self refresh exit looks at the live pin, not the registered copy,
    // since the receivers behind the capture flop are asleep
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_mode <= PWR_ON;
        end else begin
            case (power_mode)
                PWR_ON: begin
                    if (cke_prev && !cmd_q.cke) begin
                        if (op == OP_REF && bank_open == '0)
                            power_mode <= PWR_SREF;
                        else if (bank_open != '0)
                            power_mode <= PWR_APD;
                        else
                            power_mode <= PWR_PPD;
                    end
                end
                PWR_APD, PWR_PPD: begin
                    if (cmd_q.cke) power_mode <= PWR_ON;
                end
                PWR_SREF: begin
                    if (cmd.cke) power_mode <= PWR_ON;
                end
                default: power_mode <= PWR_ON;
            endcase
        end
    end

    // ==================================================
    // mode registers
    // opcode from address
    // async reset
    // ba[2] set names no register, so such a load is dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NMR; i++) mode_reg[i] <= MR_RESET;
        end else if (cmd_ok && op == OP_MRS && !cmd_q.ba[BANK_W-1]) begin
            mode_reg[cmd_q.ba[1:0]] <= cmd_q.addr;
        end
    end

    // ==================================================
    // termination
    // odt gated by mode register
    // nominal termination off in mode register 1 means the odt pin is ignored;
    // self refresh also shuts the odt receiver
    assign rtt_enabled = mode_reg[1][MR_RTT_B0] | mode_reg[1][MR_RTT_B1] | mode_reg[1][MR_RTT_B2];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            odt_on <= 1'b0;
        end else begin
            odt_on <= cmd_q.odt && rtt_enabled && (power_mode != PWR_SREF);
        end
    end

    // ==================================================
    // bank row tracking
    // one bank or all
    assign act_cmd  = cmd_ok && op == OP_ACT;
    assign pre_one  = cmd_ok && op == OP_PRE && !cmd_q.addr[A_AP];
    assign pre_all  = cmd_ok && op == OP_PRE && cmd_q.addr[A_AP];
    assign ap_close = bst != BST_IDLE && bst_last && bst_ap;

    generate
        for (genvar b = 0; b < NBANK; b++) begin : g_bank
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    bank_open[b] <= 1'b0;
                    bank_row[b]  <= '0;
                end else if (act_cmd && cmd_q.ba == BANK_W'(b)) begin
                    bank_open[b] <= 1'b1;
                    bank_row[b]  <= cmd_q.addr[ROW_W-1:0];
                end else if (pre_all || (pre_one && cmd_q.ba == BANK_W'(b))
                             || (ap_close && bst_bank == BANK_W'(b))) begin
                    bank_open[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==================================================
    // burst sequencer
    // column and auto precharge
    // burst chop select
    // a write is refused while the buffer is full, so nothing is half taken
    assign bst_last = (beat == beat_total - 4'h1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bst        <= BST_IDLE;
            beat       <= '0;
            beat_total <= BEATS_FULL;
            bst_bank   <= '0;
            bst_col    <= '0;
            bst_ap     <= 1'b0;
        end else begin
            case (bst)
                BST_IDLE: begin
                    if (cmd_ok && bank_open[cmd_q.ba] &&
                        ((op == OP_WR && fifo_in_ready) || op == OP_RD)) begin
                        bst        <= (op == OP_WR) ? BST_WRITE : BST_READ;
                        beat       <= '0;
                        beat_total <= burst_beats(mode_reg[0][MR_BL_HI:MR_BL_LO], cmd_q.addr[A_BC]);
                        bst_bank   <= cmd_q.ba;
                        bst_col    <= {cmd_q.addr[COL_HI], 1'b0, cmd_q.addr[2:0]} & {1'b1, 1'b0, 3'h0};
                        bst_ap     <= cmd_q.addr[A_AP];
                    end
                end
                BST_WRITE, BST_READ: begin
                    beat <= beat + 4'h1;
                    if (bst_last) bst <= BST_IDLE;
                end
                default: bst <= BST_IDLE;
            endcase
        end
    end

    // ==================================================
    // write capture
    // centered write strobe
    // each lane's beat is taken on a strobe toggle seen at the clock edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dqs_prev <= '0;
        end else begin
            dqs_prev <= dqs_i;
        end
    end

    // upper mask drop
    // a masked lane beside a written lane is carried with its byte enable cleared, old data kept
    always_comb begin
        wbeat.addr  = {bst_bank, bst_col[COL_HI], beat[2:0]};
        wbeat.data  = dq_i;
        wbeat.be[0] = (dqs_i[0] != dqs_prev[0]) && !dm[0];
        wbeat.be[1] = (dqs_i[1] != dqs_prev[1]) && !dm[1];
        wbeat_valid = (bst == BST_WRITE) && (wbeat.be != '0);
    end

    // buffer between the pins and the array; reads own the array port,
    // so the drain side stalls during read bursts and pending write beats wait in the buffer
    sdrpin_fifo #(
        .WIDTH ($bits(sdrpin_beat_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (wbeat),
        .in_valid  (wbeat_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (drain),
        .out_valid (drain_valid),
        .out_ready (drain_ready)
    );

    // ==================================================
    // array port
    // read wins the single port; the pending writes wait
    assign mem_re      = (bst == BST_READ);
    assign drain_ready = !mem_re;
    assign mem_addr    = mem_re ? {bst_bank, bst_col[COL_HI], beat[2:0]} : drain.addr;

    sdrpin_mem #(
        .AW (MEM_AW),
        .DW (DQ_W)
    ) u_mem (
        .clk_sys (clk_sys),
        .re      (mem_re),
        .we      (drain_valid && drain_ready),
        .addr    (mem_addr),
        .wdata   (drain.data),
        .be      (drain.be),
        .rdata   (mem_rdata)
    );

    // ==================================================
    // read drive
    // edge-aligned read strobe
    // strobe changes level on the same edge as each data beat
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_v1   <= 1'b0;
            rd_lsb1 <= 1'b0;
            dq_o    <= '0;
            dq_oe   <= 1'b0;
            dqs_o   <= '0;
            dqs_c_o <= '1;
            dqs_oe  <= 1'b0;
        end else begin
            rd_v1   <= mem_re;
            rd_lsb1 <= beat[0];
            dq_o    <= rd_v1 ? mem_rdata : '0;
            dq_oe   <= rd_v1;
            dqs_o   <= {LANES{rd_v1 && !rd_lsb1}};
            dqs_c_o <= {LANES{!(rd_v1 && !rd_lsb1)}};
            dqs_oe  <= rd_v1;
        end
    end

    // a full buffer is shown so the controller can hold off its writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_stall <= 1'b0;
        end else begin
            write_stall <= !fifo_in_ready;
        end
    end

endmodule

// File: sdrpin_top_test.sv
// self-checking bench for the x16 dram pin interface
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, s); end end
module sdrpin_top_test
    import sdrpin_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] MRS = 3'h0, REF = 3'h1, PRE = 3'h2, ACT = 3'h3, WR = 3'h4, RD = 3'h5, NOP = 3'h7;
    logic             clk_sys = 1'b0;
    logic             rst = 1'b0;
    sdrpin_cmd_t      cmd;
    logic [LANES-1:0] dm, dqs_i, dqs_o, dqs_c_o;
    logic [DQ_W-1:0]  dq_i, dq_o, note;
    logic             dq_oe, dqs_oe, odt_on, write_stall;
    sdrpin_pwr_t      power_mode;
    int               fail_count = 0;
    int               checks = 0;
    int               cyc = 0;
    logic [15:0]      exp_q [$];
    logic [15:0]      shadow [8][2][8];

    sdrpin_ctrl_model u_ctrl (.clk_sys(clk_sys), .cmd(cmd), .dm(dm), .dq_i(dq_i), .dqs_i(dqs_i));
    sdrpin_top u_sdrpin_top (
        .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .dm(dm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe), .odt_on(odt_on),
        .power_mode(power_mode), .write_stall(write_stall)
    );

    // ==========================================
    // clock, hang guard and verdict
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // every beat seen takes the oldest note; a beat with no note is an error
    always @(posedge clk_sys) begin
        if (rst === 1'b0 && dq_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("spare beat", 1'b0, 1'b1)
            end else begin
                note = exp_q.pop_front();
                `CHK("dq_o", note, dq_o)
            end
        end
    end

    // ==========================================
    // driver tasks
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rchk();
        `CHK("dq_oe", 1'b0, dq_oe)
        `CHK("dqs_c_o", 2'h3, dqs_c_o)
        `CHK("odt_on", 1'b0, odt_on)
        `CHK("power_mode", PWR_ON, power_mode)
        `CHK("write_stall", 1'b0, write_stall)
    endtask
    task automatic wr(input logic [2:0] b, input logic g, input logic a12, input logic msk, input int n);
        logic [15:0] d [8];
        logic [1:0]  m [8];
        for (int k = 0; k < n; k++) begin
            d[k] = 16'($urandom);
            m[k] = msk ? 2'($urandom) : 2'h0;
            // lower byte lands only with its mask low
            if (!m[k][0]) shadow[b][g][k][7:0] = d[k][7:0];
            // upper byte lands only with its mask low
            if (!m[k][1]) shadow[b][g][k][15:8] = d[k][15:8];
        end
        u_ctrl.put(WR, b, {1'b0, a12, 7'h0, g, 4'h0});
        u_ctrl.wburst(d, m, n);
        settle(4);
    endtask
    // n is the number of beats expected back, zero where the read is refused
    task automatic rd(input logic [2:0] b, input logic g, input logic a12, input logic ap, input int n,
                      input logic cs_n = 1'b0);
        for (int k = 0; k < n; k++) exp_q.push_back(shadow[b][g][k]);
        u_ctrl.put(RD, b, {1'b0, a12, 1'b0, ap, 5'h0, g, 4'h0}, cs_n);
        settle(12);
    endtask
    task automatic pins(input logic cke, input logic odt, input int n);
        u_ctrl.put(NOP, 3'h0, 14'h0, 1'b1, cke, odt);
        settle(n);
    endtask

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h28ff));
        // a real rising edge, so the async reset reaches every flop that has one before the first clock
        #1;
        rst = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rchk();
        pins(1'b1, 1'b1, 4);
        `CHK("odt_on", 1'b0, odt_on)
        u_ctrl.put(MRS, 3'h0, {12'h0, BL_OTF});
        u_ctrl.put(ACT, 3'h2, 14'($urandom));
        wr(3'h2, 1'b0, 1'b1, 1'b0, 8);
        wr(3'h2, 1'b0, 1'b1, 1'b1, 8);
        rd(3'h2, 1'b0, 1'b1, 1'b0, 8);
        wr(3'h2, 1'b1, 1'b0, 1'b0, 4);
        rd(3'h2, 1'b1, 1'b0, 1'b0, 4);
        $display("test masks and burst chop done");
        u_ctrl.put(ACT, 3'h5, 14'($urandom));
        wr(3'h5, 1'b0, 1'b1, 1'b0, 8);
        rd(3'h2, 1'b0, 1'b1, 1'b0, 8);
        rd(3'h5, 1'b0, 1'b1, 1'b0, 8);
        rd(3'h5, 1'b0, 1'b1, 1'b0, 0, 1'b1);
        u_ctrl.put(PRE, 3'h5, 14'h0);
        rd(3'h5, 1'b0, 1'b1, 1'b0, 0);
        rd(3'h2, 1'b0, 1'b1, 1'b1, 8);
        rd(3'h2, 1'b0, 1'b1, 1'b0, 0);
        $display("test banks, precharge and select done");
        u_ctrl.put(MRS, 3'h0, {12'h0, BL_FIXED4});
        u_ctrl.put(MRS, 3'h1, 14'h0004);
        pins(1'b1, 1'b1, 4);
        `CHK("odt_on", 1'b1, odt_on)
        pins(1'b1, 1'b0, 4);
        `CHK("odt_on", 1'b0, odt_on)
        u_ctrl.put(ACT, 3'h3, 14'($urandom));
        wr(3'h3, 1'b0, 1'b1, 1'b0, 4);
        rd(3'h3, 1'b0, 1'b1, 1'b0, 4);
        $display("test mode registers and termination done");
        pins(1'b0, 1'b0, 4);
        `CHK("power_mode", PWR_APD, power_mode)
        pins(1'b1, 1'b0, 4);
        `CHK("power_mode", PWR_ON, power_mode)
        u_ctrl.put(PRE, 3'h0, 14'h0400);
        pins(1'b0, 1'b0, 4);
        `CHK("power_mode", PWR_PPD, power_mode)
        u_ctrl.put(ACT, 3'h4, 14'h0, 1'b0, 1'b0);
        pins(1'b1, 1'b0, 4);
        rd(3'h4, 1'b0, 1'b1, 1'b0, 0);
        rd(3'h3, 1'b0, 1'b1, 1'b0, 0);
        u_ctrl.put(REF, 3'h0, 14'h0, 1'b0, 1'b0);
        settle(4);
        `CHK("power_mode", PWR_SREF, power_mode)
        pins(1'b1, 1'b0, 4);
        `CHK("power_mode", PWR_ON, power_mode)
        $display("test power states done");
        u_ctrl.put(ACT, 3'h1, 14'h0);
        pins(1'b0, 1'b1, 4);
        rst = 1'b1;
        #1;
        rchk();
        settle(2);
        rst = 1'b0;
        pins(1'b1, 1'b1, 4);
        `CHK("odt_on", 1'b0, odt_on)
        rd(3'h1, 1'b0, 1'b1, 1'b0, 0);
        $display("test reset in mid-run done");
        `CHK("notes left", 0, exp_q.size())
        report_and_stop();
    end
endmodule
